//--- rtl/reader_mode_control_regs.sv
// operation control, mode and bit rate registers with their decoding
//
// Contract
// - bit 7 turns oscillator and regulator on
// - bit 6 enables reception
// - bit 5 picks both or single channel
// - bit 4 picks automatic or manual selection
// - bit 3 enables transmit, set by field-on
// - active peer mode clears transmit after finish
// - bit 2 enables wake-up mode
// - mode bit 7 picks initiator or target
// - initiator codes in bits 6 to 3
// - target codes: rate detection, normal peer
// - undefined mode disables transmit and receive
// - auto collision avoidance on field off
// - mode and rate reload on set-default
// - operation control defaults only at power-up
// - rate register: transmit high, receive low
// - rate codes fc/128 through fc/2
// - very high transmit only in type B
// - very high receive only fc/4
// - unsupported rate disables transmit and receive
// - go-normal command loads rate register
`timescale 1ns/1ps

module reader_mode_control_regs
    import reader_mode_pkg::*;
(
    // clock and power-up reset
    input wire logic clk,
    input wire logic rst,
    // register port from the serial interface
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // direct commands, one-cycle pulses
    input wire logic setDefaultCmd,
    input wire logic fieldOnCmd,
    input wire logic goNormalCmd,
    input wire logic [7:0] goNormalRate,
    // events and settings from neighbouring blocks
    input wire logic txFinished,
    input wire logic extFieldOff,
    input wire logic channelPickBit,
    // decoded controls
    output frontend_t frontEnd,
    output protocol_t protocol,
    output logic [3:0] txRate,
    output logic [3:0] rxRate,
    output logic linkValid,
    output logic collisionAvoidStart
);

    // decode of role and operation-mode code
    function automatic protocol_t decodeMode(input logic role, input logic [3:0] code);
        protocol_t p;
        p = PROTO_NONE;
        if (!role) begin
            unique case (code)
                OM_P2P: p = PROTO_P2P_INIT;
                OM_ISO_A: p = PROTO_ISO_A;
                OM_ISO_B: p = PROTO_ISO_B;
                OM_TYPE3: p = PROTO_TYPE3;
                OM_TYPE1: p = PROTO_TYPE1;
                OM_SUBC: p = PROTO_SUBC_STREAM;
                OM_BPSK: p = PROTO_BPSK_STREAM;
                default: p = PROTO_NONE;
            endcase
        end else begin
            unique case (code)
                OM_TGT_DETECT: p = PROTO_P2P_TGT_DETECT;
                OM_TGT_NORMAL: p = PROTO_P2P_TGT_NORMAL;
                default: p = PROTO_NONE;
            endcase
        end
        return p;
    endfunction : decodeMode

    // rate code check, shared by transmit and receive
    function automatic logic rateSupported(input logic [3:0] code, input logic isTx,
                                           input logic isoB);
        logic ok;
        ok = 1'b0;
        if (code <= RATE_FC16) begin
            ok = 1'b1;
        end else if (code <= RATE_FC2) begin
            ok = isTx ? isoB : (code == RATE_FC4);
        end
        return ok;
    endfunction : rateSupported

    // stored registers
    logic [7:0] opCtrl_r;
    logic [7:0] opCtrl_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic [7:0] rate_r;
    logic [7:0] rate_nxt;

    // address decode of the register port
    wire logic wrOpc = regWrite && (regAddr == OPCTRL_ADDR);
    wire logic wrMode = regWrite && (regAddr == MODE_ADDR);
    wire logic wrRate = regWrite && (regAddr == RATE_ADDR);
    wire logic [7:0] rdMux = (regAddr == OPCTRL_ADDR) ? opCtrl_r :
                             (regAddr == MODE_ADDR) ? mode_r :
                             (regAddr == RATE_ADDR) ? rate_r : 8'h00;

    // field views of the stored registers
    wire logic roleTarget = mode_r[MODE_ROLE_BIT];
    wire logic [3:0] modeCode = mode_r[MODE_CODE_HI:MODE_CODE_LO];
    wire logic [3:0] txCode = rate_r[RATE_TX_HI:RATE_TX_LO];
    wire logic [3:0] rxCode = rate_r[RATE_RX_HI:RATE_RX_LO];

    // mode and rate checks
    wire protocol_t protoSel = decodeMode(roleTarget, modeCode);
    wire logic modeOk = (protoSel != PROTO_NONE);
    wire logic isoBSel = (protoSel == PROTO_ISO_B);
    wire logic txRateOk = rateSupported(txCode, 1'b1, isoBSel);
    wire logic rxRateOk = rateSupported(rxCode, 1'b0, isoBSel);
    wire logic linkOk = modeOk && txRateOk && rxRateOk;
    wire logic activeP2p = (protoSel == PROTO_P2P_INIT) ||
                           (protoSel == PROTO_P2P_TGT_DETECT) ||
                           (protoSel == PROTO_P2P_TGT_NORMAL);

    // operation control next value: host write, then finish clear, then field-on set;
    // the set is last so a field-on in the same cycle as a clear is never lost
    always_comb begin
        opCtrl_nxt = opCtrl_r;
        if (wrOpc) begin
            opCtrl_nxt = regWdata & OPC_WR_MASK;
        end
        if (txFinished && activeP2p) begin
            opCtrl_nxt[OPC_TX_BIT] = 1'b0;
        end
        if (fieldOnCmd) begin
            opCtrl_nxt[OPC_TX_BIT] = 1'b1;
        end
    end

    // mode next value: set-default outranks a host write in the same cycle
    always_comb begin
        mode_nxt = mode_r;
        if (setDefaultCmd) begin
            mode_nxt = MODE_RESET;
        end else if (wrMode) begin
            mode_nxt = regWdata & MODE_WR_MASK;
        end
    end

    // rate next value: set-default, then go-normal load, then host write
    always_comb begin
        rate_nxt = rate_r;
        if (setDefaultCmd) begin
            rate_nxt = RATE_RESET;
        end else if (goNormalCmd) begin
            rate_nxt = goNormalRate;
        end else if (wrRate) begin
            rate_nxt = regWdata;
        end
    end

    // storage; operation control ignores set-default, only power-up clears it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opCtrl_r <= OPC_RESET;
            mode_r <= MODE_RESET;
            rate_r <= RATE_RESET;
        end else begin
            opCtrl_r <= opCtrl_nxt;
            mode_r <= mode_nxt;
            rate_r <= rate_nxt;
        end
    end

    // front end enables; only transmit and receive are gated off whenever the mode or a rate is unusable
    wire logic singleChn = opCtrl_r[OPC_CHN_BIT];
    frontend_t feNxt;
    always_comb begin
        feNxt.oscOn = opCtrl_r[OPC_OSC_BIT];
        feNxt.rxOn = opCtrl_r[OPC_RX_BIT] && linkOk;
        feNxt.amOn = !singleChn || !channelPickBit;
        feNxt.pmOn = !singleChn || channelPickBit;
        feNxt.manualSel = !singleChn && opCtrl_r[OPC_MAN_BIT];
        feNxt.txOn = opCtrl_r[OPC_TX_BIT] && linkOk;
        feNxt.wakeupOn = opCtrl_r[OPC_WAKE_BIT];
    end

    // registered outputs; one cycle behind the stored registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frontEnd <= '0;
            protocol <= PROTO_NONE;
            txRate <= RATE_FC128;
            rxRate <= RATE_FC128;
            linkValid <= 1'b0;
            collisionAvoidStart <= 1'b0;
            regRdata <= 8'h00;
        end else begin
            frontEnd <= feNxt;
            protocol <= protoSel;
            txRate <= txCode;
            rxRate <= rxCode;
            linkValid <= linkOk;
            collisionAvoidStart <= mode_r[MODE_CA_BIT] && extFieldOff;
            regRdata <= regRead ? rdMux : 8'h00;
        end
    end

    // checks on the design's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_fieldon_sets_tx: assert property (
        fieldOnCmd |=> opCtrl_r[OPC_TX_BIT])
        else $error("field-on did not set transmit enable");

    a_finish_clears_tx: assert property (
        txFinished && activeP2p && !fieldOnCmd && !wrOpc |=> !opCtrl_r[OPC_TX_BIT])
        else $error("transmit enable kept after peer transmission");

    a_osc_follows_write: assert property (
        wrOpc |-> ##2 frontEnd.oscOn == $past(regWdata[OPC_OSC_BIT], 2))
        else $error("oscillator enable does not follow written bit");

    a_bad_mode_quiet: assert property (
        protocol == PROTO_NONE |-> !frontEnd.txOn && !frontEnd.rxOn && !linkValid)
        else $error("link active with undefined mode");

    a_setdef_reload: assert property (
        setDefaultCmd |=> mode_r == MODE_RESET && rate_r == RATE_RESET)
        else $error("set-default did not reload mode and rate");

    a_setdef_keeps_opc: assert property (
        setDefaultCmd && !wrOpc && !fieldOnCmd && !txFinished |=> $stable(opCtrl_r))
        else $error("set-default changed operation control");

    a_vhbr_tx_typeb: assert property (
        frontEnd.txOn && txRate >= RATE_FC8 |-> protocol == PROTO_ISO_B && txRate <= RATE_FC2)
        else $error("very high transmit rate outside type B");

    a_vhbr_rx_fc4: assert property (
        frontEnd.rxOn |-> rxRate <= RATE_FC16 || rxRate == RATE_FC4)
        else $error("unsupported receive rate in use");

    a_ca_launch: assert property (
        collisionAvoidStart |-> $past(extFieldOff) && $past(mode_r[MODE_CA_BIT]))
        else $error("collision avoidance launched without cause");

    a_gonormal_load: assert property (
        goNormalCmd && !setDefaultCmd |-> ##2 txRate == $past(goNormalRate[7:4], 2))
        else $error("go-normal did not load transmit rate");

    a_unused_zero: assert property (
        regWrite |=> opCtrl_r[1:0] == 2'b00 && mode_r[2:1] == 2'b00)
        else $error("unused bits hold a one");

    c_peer_finish: cover property (txFinished && activeP2p && opCtrl_r[OPC_TX_BIT]);
    c_typeb_vhbr: cover property (frontEnd.txOn && protocol == PROTO_ISO_B && txRate == RATE_FC2);
    c_ca_start: cover property (collisionAvoidStart);
    c_single_pm: cover property (frontEnd.rxOn && !frontEnd.amOn && frontEnd.pmOn);

endmodule : reader_mode_control_regs

//--- rtl/reader_mode_pkg.sv
// package: register map, field layout, codes and carriers of the mode control bank
package reader_mode_pkg;

    // register offsets
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] OPCTRL_ADDR = 6'h02;
    localparam logic [ADDR_W-1:0] MODE_ADDR = 6'h03;
    localparam logic [ADDR_W-1:0] RATE_ADDR = 6'h04;

    // operation control field positions
    localparam int OPC_OSC_BIT = 7;
    localparam int OPC_RX_BIT = 6;
    localparam int OPC_CHN_BIT = 5;
    localparam int OPC_MAN_BIT = 4;
    localparam int OPC_TX_BIT = 3;
    localparam int OPC_WAKE_BIT = 2;

    // mode register field positions
    localparam int MODE_ROLE_BIT = 7;
    localparam int MODE_CODE_HI = 6;
    localparam int MODE_CODE_LO = 3;
    localparam int MODE_CA_BIT = 0;

    // bit rate register field positions
    localparam int RATE_TX_HI = 7;
    localparam int RATE_TX_LO = 4;
    localparam int RATE_RX_HI = 3;
    localparam int RATE_RX_LO = 0;

    // writable bits and reset values
    localparam logic [7:0] OPC_WR_MASK = 8'hFC;
    localparam logic [7:0] MODE_WR_MASK = 8'hF9;
    localparam logic [7:0] OPC_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h08;
    localparam logic [7:0] RATE_RESET = 8'h00;

    // operation-mode codes
    localparam logic [3:0] OM_P2P = 4'h0;
    localparam logic [3:0] OM_ISO_A = 4'h1;
    localparam logic [3:0] OM_ISO_B = 4'h2;
    localparam logic [3:0] OM_TYPE3 = 4'h3;
    localparam logic [3:0] OM_TYPE1 = 4'h4;
    localparam logic [3:0] OM_SUBC = 4'hE;
    localparam logic [3:0] OM_BPSK = 4'hF;
    localparam logic [3:0] OM_TGT_DETECT = 4'h0;
    localparam logic [3:0] OM_TGT_NORMAL = 4'h1;

    // rate codes, fc/128 down to fc/2
    localparam logic [3:0] RATE_FC128 = 4'h0;
    localparam logic [3:0] RATE_FC64 = 4'h1;
    localparam logic [3:0] RATE_FC32 = 4'h2;
    localparam logic [3:0] RATE_FC16 = 4'h3;
    localparam logic [3:0] RATE_FC8 = 4'h4;
    localparam logic [3:0] RATE_FC4 = 4'h5;
    localparam logic [3:0] RATE_FC2 = 4'h6;

    // decoded protocol selection
    typedef enum logic [3:0] {
        PROTO_NONE = 4'h0,
        PROTO_P2P_INIT = 4'h1,
        PROTO_ISO_A = 4'h2,
        PROTO_ISO_B = 4'h3,
        PROTO_TYPE3 = 4'h4,
        PROTO_TYPE1 = 4'h5,
        PROTO_SUBC_STREAM = 4'h6,
        PROTO_BPSK_STREAM = 4'h7,
        PROTO_P2P_TGT_DETECT = 4'h8,
        PROTO_P2P_TGT_NORMAL = 4'h9
    } protocol_t;

    // enables handed to the analog front end and framing
    typedef struct packed {
        logic oscOn;
        logic rxOn;
        logic amOn;
        logic pmOn;
        logic manualSel;
        logic txOn;
        logic wakeupOn;
    } frontend_t;

endpackage : reader_mode_pkg

//--- tb/host_model.sv
// host model driving the register port of the mode control bank
`timescale 1ns/1ps

module host_model
    import reader_mode_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output logic regWrite,
    output logic regRead,
    output logic [ADDR_W-1:0] regAddr,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata
);
    // idle values inverted on release so stale data never looks valid
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 6'h3F;
        regWdata = 8'hA5;
    end

    // one write, held across exactly one sampling edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regAddr = ~a;
        regWdata = ~d;
    endtask : wr

    // one read, data taken once the registered answer has landed
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        d = regRdata;
        regRead = 1'b0;
        regAddr = ~a;
    endtask : rd
endmodule : host_model

//--- tb/tb_top.sv
// self-checking bench for the mode control register bank
`timescale 1ns/1ps

module tb_top import reader_mode_pkg::*; ;
    localparam logic [4:0] SD = 5'h10, FO = 5'h08, GN = 5'h04, TF = 5'h02, EF = 5'h01;
    logic clk, rst, regWrite, regRead, channelPickBit, linkValid, collisionAvoidStart;
    logic [ADDR_W-1:0] regAddr;
    logic [7:0] regWdata, regRdata, goNormalRate, rv;
    logic [4:0] cmd;
    logic [3:0] txRate, rxRate;
    frontend_t frontEnd;
    protocol_t protocol;
    int errors, n_tests, cycles;

    host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata));

    reader_mode_control_regs DUT (.clk(clk), .rst(rst), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .setDefaultCmd(cmd[4]), .fieldOnCmd(cmd[3]), .goNormalCmd(cmd[2]),
        .goNormalRate(goNormalRate), .txFinished(cmd[1]), .extFieldOff(cmd[0]),
        .channelPickBit(channelPickBit), .frontEnd(frontEnd), .protocol(protocol),
        .txRate(txRate), .rxRate(rxRate), .linkValid(linkValid),
        .collisionAvoidStart(collisionAvoidStart));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    // one-cycle command pulse; register has taken it on return
    task automatic pulse(input logic [4:0] c);
        @(posedge clk);
        #1;
        cmd = c;
        tick();
        cmd = 5'h00;
    endtask : pulse

    function automatic logic [3:0] expProto(input logic role, input logic [3:0] c);
        case ({role, c})
            5'h00: return PROTO_P2P_INIT;
            5'h01: return PROTO_ISO_A;
            5'h02: return PROTO_ISO_B;
            5'h03: return PROTO_TYPE3;
            5'h04: return PROTO_TYPE1;
            5'h0E: return PROTO_SUBC_STREAM;
            5'h0F: return PROTO_BPSK_STREAM;
            5'h10: return PROTO_P2P_TGT_DETECT;
            5'h11: return PROTO_P2P_TGT_NORMAL;
            default: return PROTO_NONE;
        endcase
    endfunction : expProto

    function automatic logic rateOk(input logic [3:0] t, input logic [3:0] r, input logic isoB);
        return (t <= 4'h3 || (t <= 4'h6 && isoB)) && (r <= 4'h3 || r == 4'h5);
    endfunction : rateOk

    task automatic test_reset();
        host.rd(OPCTRL_ADDR, rv);
        chk("opctrl", 8'h00, rv);
        host.rd(MODE_ADDR, rv);
        chk("mode", 8'h08, rv);
        host.rd(RATE_ADDR, rv);
        chk("rate", 8'h00, rv);
        chk("protocol", PROTO_ISO_A, protocol);
        chk("linkValid", 8'h01, linkValid);
    endtask : test_reset

    // enables, channel choice and unused bits of operation control
    task automatic test_opctrl();
        host.wr(OPCTRL_ADDR, 8'hFF);
        tick();
        chk("frontEnd", 8'h73, frontEnd);
        host.rd(OPCTRL_ADDR, rv);
        chk("opctrl", 8'hFC, rv);
        channelPickBit = 1'b1;
        tick();
        tick();
        chk("frontEnd", 8'h6B, frontEnd);
        host.wr(OPCTRL_ADDR, 8'h50);
        tick();
        chk("frontEnd", 8'h3C, frontEnd);
        host.wr(OPCTRL_ADDR, 8'h40);
        channelPickBit = 1'b0;
        tick();
        chk("frontEnd", 8'h38, frontEnd);
        host.wr(OPCTRL_ADDR, 8'h00);
    endtask : test_opctrl

    // every role and code, defined or not
    task automatic test_mode();
        for (int i = 0; i < 32; i++) begin
            logic [7:0] v;
            logic [3:0] ep;
            v = {i[4], i[3:0], 3'b111};
            ep = expProto(i[4], i[3:0]);
            host.wr(MODE_ADDR, v);
            tick();
            chk("protocol", ep, protocol);
            chk("linkValid", ep != PROTO_NONE, linkValid);
            host.rd(MODE_ADDR, rv);
            chk("mode", v & 8'hF9, rv);
        end
    endtask : test_mode

    // every rate pair under type A and type B, transmit and receive enabled so the
    // gating is seen on the enables too; leaves control and rate cleared afterwards
    task automatic test_rate();
        host.wr(OPCTRL_ADDR, 8'h48);
        for (int m = 0; m < 2; m++) begin
            host.wr(MODE_ADDR, m ? 8'h10 : 8'h08);
            for (int i = 0; i < 256; i++) begin
                logic ok;
                ok = rateOk(i[7:4], i[3:0], m[0]);
                host.wr(RATE_ADDR, i[7:0]);
                tick();
                chk("txRate", i[7:4], txRate);
                chk("rxRate", i[3:0], rxRate);
                chk("linkValid", ok, linkValid);
                chk("txOn", ok, frontEnd.txOn);
                chk("rxOn", ok, frontEnd.rxOn);
            end
        end
        host.wr(OPCTRL_ADDR, 8'h00);
        host.wr(RATE_ADDR, 8'h00);
    endtask : test_rate

    task automatic test_cmds();
        host.wr(MODE_ADDR, 8'h00);
        pulse(FO);
        tick();
        chk("txOn", 8'h01, frontEnd.txOn);
        pulse(TF);
        host.rd(OPCTRL_ADDR, rv);
        chk("opctrl", 8'h00, rv);
        // type A, collision avoidance still off
        host.wr(MODE_ADDR, 8'h08);
        pulse(FO);
        pulse(TF);
        host.rd(OPCTRL_ADDR, rv);
        chk("opctrl", 8'h08, rv);
        pulse(EF);
        chk("collisionAvoidStart", 8'h00, collisionAvoidStart);
        // non-default rate and mode so the set-default reload is visible
        host.wr(RATE_ADDR, 8'h11);
        host.wr(MODE_ADDR, 8'h09);
        pulse(EF);
        chk("collisionAvoidStart", 8'h01, collisionAvoidStart);
        tick();
        chk("collisionAvoidStart", 8'h00, collisionAvoidStart);
        pulse(SD);
        host.rd(MODE_ADDR, rv);
        chk("mode", 8'h08, rv);
        host.rd(RATE_ADDR, rv);
        chk("rate", 8'h00, rv);
        host.rd(OPCTRL_ADDR, rv);
        chk("opctrl", 8'h08, rv);
        goNormalRate = 8'h22;
        pulse(GN);
        host.rd(RATE_ADDR, rv);
        chk("rate", 8'h22, rv);
    endtask : test_cmds

    task automatic complete_run();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 20000) begin
                errors++;
                complete_run();
            end
        end
    end

    initial begin
        rst = 1'b1;
        cmd = 5'h00;
        goNormalRate = 8'h00;
        channelPickBit = 1'b0;
        errors = 0;
        n_tests = 0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        test_reset();
        test_opctrl();
        test_mode();
        test_rate();
        test_cmds();
        complete_run();
    end
endmodule : tb_top
